// ===== hdl/adc_port_pkg.sv
// Purpose: Shared constants and types of the converter's serial output port.
// Assumes: Master clock is ref_clk, so every timing count is in its cycles.
// Notes:   Counts are master clock cycles, not nanoseconds.
package adc_port_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned WORD_BITS     = 24;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned LEAD_MCLK     = 8;
  localparam int unsigned TAIL_MCLK     = 8;
  localparam int unsigned GD_MCLK       = 160;
  localparam int unsigned HP_MCLK       = 354;
  localparam int unsigned WARN_MCLK     = 2;
  localparam logic [4:0]  LEAD_LAST     = 5'(LEAD_MCLK - 1);
  localparam logic [4:0]  TAIL_LAST     = 5'(TAIL_MCLK - 1);
  localparam logic [4:0]  BITS_LAST     = 5'(WORD_BITS - 1);
  localparam logic [4:0]  BITS_ALL      = 5'(WORD_BITS);
  localparam logic [8:0]  GD_LAST       = 9'(GD_MCLK - 1);
  localparam logic [8:0]  WARN_AT       = 9'(GD_MCLK - 1 - WARN_MCLK);
  localparam logic [8:0]  HP_LAST       = 9'(HP_MCLK - 1);
  // Serial clock bit resets low: a host idling low must not look like a fall
  localparam logic [2:0]  SYNC_RST      = 3'h3;

  typedef enum logic {
    external_clocked_port_mode = 1'b0,
    self_clocked_port_mode     = 1'b1
  } port_mode_t;

  typedef enum logic [2:0] {
    ST_EMPTY = 3'b000,
    ST_HOLD  = 3'b001,
    ST_LEAD  = 3'b010,
    ST_SHIFT = 3'b011,
    ST_TAIL  = 3'b100
  } port_state_t;
endpackage

// ===== hdl/word_fifo.sv
// Purpose: Result word buffer between the filter and the serial port.
// Assumes: Single clock; push and pop use valid/ready handshakes.
// Notes:   Pointers carry one extra bit so full and empty stay exact.
`timescale 1ns/1ns
module word_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  logic [AW:0]      nxt_wr;
  logic [AW:0]      nxt_rd;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready  = (wr_ff[AW] == rd_ff[AW]) || (wr_ff[AW-1:0] != rd_ff[AW-1:0]);
    out_valid = (wr_ff != rd_ff);
    out_data  = mem_ff[rd_ff[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    nxt_wr    = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd    = pop ? rd_ff + 1'b1 : rd_ff;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end
endmodule

// ===== hdl/adc_serial_output_port.sv
// Purpose: Serial output port of a 24-bit converter, both port roles.
// Assumes: Master clock is ref_clk; pins arrive asynchronously.
// Notes:   Chip select, serial clock in and strap pass two flip-flops
//          before use, so host edges are seen two to three cycles late.
`timescale 1ns/1ns

// Contract
// - strap high self-clocked, low externally clocked
// - first serial clock rise 8 cycles after select
// - ready returns high 8 cycles after last rise
// - self-clocked: clock and data float while deselected
// - external: data driven only while selected
// - external: ready high after final falling edge
// - group delay 160 inside 354-cycle high-power period
// - finished word loads port, ready goes low
// - external, selected: unread word dropped two cycles before next end
// - each word is 24 bits
module adc_serial_output_port
  import adc_port_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 port_role_strap,
  input  wire logic                 chip_sel_n,
  input  wire logic                 sclk_in,
  input  wire logic                 conv_start,
  input  wire logic [WORD_BITS-1:0] conv_sample,
  output logic                      start_ready,
  output logic                      high_power,
  output logic                      rdy_n,
  output logic                      serial_result_out,
  output logic                      sdo_oe,
  output logic                      sclk_out,
  output logic                      sclk_oe
);
  // Bit 0 strap, bit 1 chip select, bit 2 serial clock in
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic       sclk_prev_ff;
  logic       strap_s;
  logic       cs_s;
  logic       sclk_fall;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_ff        <= SYNC_RST;
      s2_ff        <= SYNC_RST;
      sclk_prev_ff <= 1'b0;
    end else begin
      s1_ff        <= {sclk_in, chip_sel_n, port_role_strap};
      s2_ff        <= s1_ff;
      sclk_prev_ff <= s2_ff[2];
    end
  end

  always_comb begin
    strap_s   = s2_ff[0];
    cs_s      = s2_ff[1];
    sclk_fall = sclk_prev_ff && !s2_ff[2];
  end

  // Conversion filter timing
  logic                 active_ff;
  logic [8:0]           gd_ff;
  logic [WORD_BITS-1:0] raw_ff;
  logic                 start_ready_ff;
  logic                 hp_ff;
  logic                 nxt_active;
  logic [8:0]           nxt_gd;
  logic [WORD_BITS-1:0] nxt_raw;
  logic                 nxt_start_ready;
  logic                 push_v;
  logic                 warn;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic                 fifo_out_ready;
  logic [WORD_BITS-1:0] fifo_out_data;

  always_comb begin
    nxt_active = active_ff;
    nxt_gd     = gd_ff;
    nxt_raw    = raw_ff;
    push_v     = active_ff && (gd_ff == GD_LAST);
    warn       = active_ff && (gd_ff == WARN_AT);
    if (conv_start && start_ready_ff) begin
      nxt_active = 1'b1;
      nxt_gd     = '0;
      nxt_raw    = conv_sample;
    end else if (active_ff) begin
      nxt_gd = gd_ff + 9'h001;
      if (gd_ff == HP_LAST) begin
        nxt_active = 1'b0;
      end
    end
    // Refusing a start while the buffer is full is the back-pressure path
    nxt_start_ready = !nxt_active && fifo_in_ready;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      active_ff      <= 1'b0;
      gd_ff          <= '0;
      raw_ff         <= '0;
      start_ready_ff <= 1'b0;
      hp_ff          <= 1'b0;
    end else begin
      active_ff      <= nxt_active;
      gd_ff          <= nxt_gd;
      raw_ff         <= nxt_raw;
      start_ready_ff <= nxt_start_ready;
      hp_ff          <= nxt_active;
    end
  end

  word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .rst       (sys_rst),
    .in_valid  (push_v),
    .in_ready  (fifo_in_ready),
    .in_data   (raw_ff),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Serial port
  port_state_t          st_ff;
  port_mode_t           mode_ff;
  logic [4:0]           cnt_ff;
  logic [4:0]           bit_ff;
  logic [WORD_BITS-1:0] word_ff;
  logic [WORD_BITS-1:0] shift_ff;
  logic                 rdy_n_ff;
  logic                 sdo_ff;
  logic                 sdo_oe_ff;
  logic                 sclk_ff;
  logic                 sclk_oe_ff;
  port_state_t          nxt_st;
  port_mode_t           nxt_mode;
  logic [4:0]           nxt_cnt;
  logic [4:0]           nxt_bit;
  logic [WORD_BITS-1:0] nxt_word;
  logic [WORD_BITS-1:0] nxt_shift;
  logic                 nxt_rdy_n;
  logic                 nxt_sclk;
  logic                 self_mode;

  always_comb begin
    nxt_st         = st_ff;
    nxt_mode       = mode_ff;
    nxt_cnt        = cnt_ff;
    nxt_bit        = bit_ff;
    nxt_word       = word_ff;
    nxt_shift      = shift_ff;
    nxt_rdy_n      = rdy_n_ff;
    nxt_sclk       = 1'b0;
    self_mode      = (mode_ff == self_clocked_port_mode);
    fifo_out_ready = (st_ff == ST_EMPTY);
    case (st_ff)
      ST_EMPTY: begin
        // Role is only taken up between words
        nxt_mode = port_mode_t'(strap_s);
        if (fifo_out_valid) begin
          nxt_word  = fifo_out_data;
          nxt_shift = fifo_out_data;
          nxt_rdy_n = 1'b0;
          nxt_bit   = '0;
          nxt_st    = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!cs_s && self_mode) begin
          nxt_cnt = '0;
          nxt_st  = ST_LEAD;
        end else if (!cs_s && sclk_fall) begin
          nxt_shift = {shift_ff[WORD_BITS-2:0], 1'b0};
          nxt_bit   = bit_ff + 5'h01;
          if (bit_ff == BITS_LAST) begin
            nxt_rdy_n = 1'b1;
            nxt_st    = ST_EMPTY;
          end
        end else if (!cs_s && warn && bit_ff == '0) begin
          nxt_rdy_n = 1'b1;
          nxt_st    = ST_EMPTY;
        end
      end
      ST_LEAD: begin
        nxt_cnt = cnt_ff + 5'h01;
        if (cs_s) begin
          nxt_st = ST_HOLD;
        end else if (cnt_ff == LEAD_LAST) begin
          nxt_sclk = 1'b1;
          nxt_bit  = 5'h01;
          nxt_st   = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_s) begin
          // A deselect mid-word restarts the same word from its MSB
          nxt_shift = word_ff;
          nxt_bit   = '0;
          nxt_st    = ST_HOLD;
        end else if (sclk_ff) begin
          nxt_shift = {shift_ff[WORD_BITS-2:0], 1'b0};
          if (bit_ff == BITS_ALL) begin
            nxt_cnt = 5'h01;
            nxt_st  = ST_TAIL;
          end
        end else begin
          nxt_sclk = 1'b1;
          nxt_bit  = bit_ff + 5'h01;
        end
      end
      ST_TAIL: begin
        nxt_cnt = cnt_ff + 5'h01;
        if (cnt_ff == TAIL_LAST) begin
          nxt_rdy_n = 1'b1;
          nxt_st    = ST_EMPTY;
        end
      end
      default: begin
        nxt_st = ST_EMPTY;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff      <= ST_EMPTY;
      mode_ff    <= external_clocked_port_mode;
      cnt_ff     <= '0;
      bit_ff     <= '0;
      word_ff    <= '0;
      shift_ff   <= '0;
      rdy_n_ff   <= 1'b1;
      sdo_ff     <= 1'b0;
      sdo_oe_ff  <= 1'b0;
      sclk_ff    <= 1'b0;
      sclk_oe_ff <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      mode_ff    <= nxt_mode;
      cnt_ff     <= nxt_cnt;
      bit_ff     <= nxt_bit;
      word_ff    <= nxt_word;
      shift_ff   <= nxt_shift;
      rdy_n_ff   <= nxt_rdy_n;
      sdo_ff     <= nxt_shift[WORD_BITS-1];
      sdo_oe_ff  <= !cs_s;
      sclk_ff    <= nxt_sclk;
      sclk_oe_ff <= !cs_s && self_mode;
    end
  end

  always_comb begin
    start_ready       = start_ready_ff;
    high_power        = hp_ff;
    rdy_n             = rdy_n_ff;
    serial_result_out = sdo_ff;
    sdo_oe            = sdo_oe_ff;
    sclk_out          = sclk_ff;
    sclk_oe           = sclk_oe_ff;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence lead_run;
    (!sclk_ff)[*8] ##1 sclk_ff;
  endsequence

  sequence tail_run;
    (!rdy_n_ff)[*8] ##1 rdy_n_ff;
  endsequence

  a_mode_from_strap: assert property (
    st_ff == ST_EMPTY |=> mode_ff == port_mode_t'($past(strap_s)))
    else $error("port role not taken from strap");

  a_lead_first_rise: assert property (
    @(posedge ref_clk) disable iff (sys_rst || cs_s)
    $rose(st_ff == ST_LEAD) |-> lead_run)
    else $error("first serial clock rise not 8 cycles after select");

  a_tail_ready_high: assert property (
    $rose(sclk_ff) && bit_ff == BITS_ALL |-> tail_run)
    else $error("ready not high 8 cycles after last rise");

  a_self_float: assert property (
    cs_s |=> !sclk_oe_ff && !sdo_oe_ff)
    else $error("pins driven while deselected");

  a_ext_drive: assert property (
    !cs_s |=> sdo_oe_ff)
    else $error("data not driven while selected");

  a_ext_last_fall: assert property (
    st_ff == ST_HOLD && !self_mode && !cs_s && sclk_fall
    && bit_ff == BITS_LAST |=> rdy_n_ff && st_ff == ST_EMPTY)
    else $error("ready not high after final falling edge");

  a_group_delay: assert property (
    $rose(active_ff) |-> ##159 push_v ##195 !active_ff)
    else $error("group delay or high-power period wrong");

  a_load_word: assert property (
    fifo_out_valid && fifo_out_ready
    |=> !rdy_n_ff && word_ff == $past(fifo_out_data))
    else $error("finished word not loaded with ready low");

  a_warn_lead: assert property (
    warn |-> ##2 push_v)
    else $error("unread drop not two cycles before end");

  a_word_bits: assert property (
    st_ff == ST_TAIL |-> bit_ff == BITS_ALL)
    else $error("word not 24 bits");

  a_half_rate: assert property (
    st_ff == ST_SHIFT && $past(st_ff) == ST_SHIFT && !cs_s
    |-> sclk_ff != $past(sclk_ff))
    else $error("serial clock not half rate");
endmodule

// ===== test/host_link_model.sv
// Purpose: Host controller model on the far side of the serial link.
// Assumes: Clock and data pins carry pull-downs while the device floats them.
// Notes:   Link clock runs only inside frames, 64 ns period, off ref_clk phase except in test_drop, where its edges land on ref_clk rises.
`timescale 1ns/1ns
module host_link_model (
  input  wire logic ref_clk,
  input  wire logic serial_result_out,
  input  wire logic sdo_oe,
  input  wire logic sclk_out,
  input  wire logic sclk_oe,
  output logic      chip_sel_n,
  output logic      sclk_in
);
  logic sdo_pin;
  logic sclk_pin;

  // A floating pin reads low, never the last driven level
  assign sdo_pin  = sdo_oe & serial_result_out;
  assign sclk_pin = sclk_oe & sclk_out;

  initial begin
    chip_sel_n = 1'b1;
    sclk_in    = 1'b0;
  end

  task automatic sel(input logic v);
    @(posedge ref_clk);
    chip_sel_n <= ~v;
  endtask

  // Samples on the rise; the device moves data after each fall
  task automatic ext_bits(input int n, output logic [23:0] w);
    w = '0;
    #1;
    repeat (n) begin
      #32;
      sclk_in = 1'b1;
      w = {w[22:0], sdo_pin};
      #32;
      sclk_in = 1'b0;
    end
  endtask

  task automatic self_bits(output logic [23:0] w);
    w = '0;
    repeat (24) begin
      @(posedge sclk_pin);
      w = {w[22:0], sdo_pin};
    end
  endtask
endmodule

// ===== test/adc_serial_output_port_bench.sv
// Purpose: Self-checking bench of the converter's serial output port.
// Assumes: Cycle marks are taken at the falling edge of ref_clk.
// Notes:   Sync delay of the pins makes select-to-clock a small range.
`timescale 1ns/1ns
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin \
  fail_count++; $display("[ERR] %0t %s", $time, m); end end
module adc_serial_output_port_bench;
  import adc_port_pkg::*;
  logic        ref_clk, sys_rst, port_role_strap, chip_sel_n, sclk_in;
  logic        conv_start, start_ready, high_power, rdy_n;
  logic        serial_result_out, sdo_oe, sclk_out, sclk_oe;
  logic [23:0] conv_sample;
  logic        sclk_q, rdy_q, hp_q;
  int          cyc, fail_count, checks, nrise, first_rise, last_rise;
  int          rdy_up, rdy_dn, hp_up, hp_len;

  adc_serial_output_port dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .port_role_strap(port_role_strap), .chip_sel_n(chip_sel_n),
    .sclk_in(sclk_in), .conv_start(conv_start), .conv_sample(conv_sample),
    .start_ready(start_ready), .high_power(high_power), .rdy_n(rdy_n),
    .serial_result_out(serial_result_out), .sdo_oe(sdo_oe),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe));

  host_link_model host_u (.ref_clk(ref_clk),
    .serial_result_out(serial_result_out), .sdo_oe(sdo_oe),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .chip_sel_n(chip_sel_n),
    .sclk_in(sclk_in));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(negedge ref_clk) begin
    cyc++;
    if (sclk_out && !sclk_q) begin
      if (nrise > 0) `CHK(cyc - last_rise, 2, "clock not half rate")
      if (nrise == 0) first_rise = cyc;
      nrise++;
      last_rise = cyc;
    end
    if (rdy_n && !rdy_q) rdy_up = cyc;
    if (!rdy_n && rdy_q) rdy_dn = cyc;
    if (high_power && !hp_q) hp_up = cyc;
    if (!high_power && hp_q) hp_len = cyc - hp_up;
    sclk_q = sclk_out;
    rdy_q = rdy_n;
    hp_q = high_power;
    // Whole run needs about 15000 cycles
    if (cyc == 40000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic wait_rdy(input logic v, input int lim, output int n);
    n = 0;
    while (rdy_n !== v && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    // Let the edge recorder finish this time step before callers read it
    #1;
    if (rdy_n !== v) begin
      fail_count++;
      $display("[ERR] %0t ready wait ran out", $time);
    end
  endtask

  task automatic set_mode(input logic v);
    @(posedge ref_clk);
    port_role_strap <= v;
    repeat (6) @(negedge ref_clk);
  endtask

  task automatic conv(input logic [23:0] s);
    int n;
    n = 0;
    while (start_ready !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(start_ready, 1'b1, "start refused")
    @(posedge ref_clk);
    conv_start <= 1'b1;
    conv_sample <= s;
    @(posedge ref_clk);
    conv_start <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic test_self;
    logic [23:0] w;
    int n, t0;
    set_mode(1'b1);
    conv(24'ha5c3e1);
    wait_rdy(1'b0, 400, n);
    `CHK(rdy_dn - hp_up, 161, "word late")
    repeat (200) @(negedge ref_clk);
    `CHK(hp_len, 354, "high power length")
    // Cut the frame after a few bits; the word must restart from its MSB
    host_u.sel(1'b1);
    repeat (20) @(negedge ref_clk);
    host_u.sel(1'b0);
    repeat (6) @(negedge ref_clk);
    `CHK(rdy_n, 1'b0, "word lost on cut frame")
    `CHK(sclk_oe, 1'b0, "clock driven after cut")
    nrise = 0;
    host_u.sel(1'b1);
    t0 = cyc;
    host_u.self_bits(w);
    `CHK(w, 24'ha5c3e1, "self word")
    `CHK(sclk_oe, 1'b1, "self clock drive")
    `CHK(first_rise - t0 inside {[11:13]}, 1'b1, "first rise")
    wait_rdy(1'b1, 20, n);
    `CHK(rdy_up - last_rise, 8, "ready tail")
    host_u.sel(1'b0);
    repeat (4) @(negedge ref_clk);
    `CHK(sclk_oe, 1'b0, "clock floats")
    `CHK(sdo_oe, 1'b0, "data floats")
    $display("test self done");
  endtask

  task automatic test_ext;
    logic [23:0] w, b;
    int n;
    set_mode(1'b0);
    conv(24'h3c5a96);
    wait_rdy(1'b0, 400, n);
    `CHK(sdo_oe, 1'b0, "data driven deselected")
    host_u.sel(1'b1);
    repeat (4) @(negedge ref_clk);
    `CHK(sdo_oe, 1'b1, "data not driven")
    `CHK(sclk_oe, 1'b0, "clock driven in ext role")
    host_u.ext_bits(23, w);
    repeat (8) @(negedge ref_clk);
    `CHK(rdy_n, 1'b0, "ready early")
    host_u.ext_bits(1, b);
    wait_rdy(1'b1, 10, n);
    `CHK(n inside {[2:5]}, 1'b1, "ready after last fall")
    `CHK({w[22:0], b[0]}, 24'h3c5a96, "ext word")
    host_u.sel(1'b0);
    repeat (4) @(negedge ref_clk);
    `CHK(sdo_oe, 1'b0, "data floats")
    $display("test ext done");
  endtask

  task automatic test_drop;
    logic [23:0] w;
    int n;
    conv(24'h0f0f0f);
    wait_rdy(1'b0, 400, n);
    host_u.sel(1'b1);
    repeat (4) @(negedge ref_clk);
    conv(24'hc0ffee);
    wait_rdy(1'b1, 400, n);
    wait_rdy(1'b0, 10, n);
    `CHK(rdy_dn - rdy_up inside {[2:3]}, 1'b1, "drop timing")
    host_u.ext_bits(24, w);
    `CHK(w, 24'hc0ffee, "newer word")
    host_u.sel(1'b0);
    repeat (8) @(negedge ref_clk);
    $display("test drop done");
  endtask

  task automatic test_fill;
    logic [23:0] w, s;
    int n;
    for (int i = 0; i < 17; i++) conv(24'h1e0000 + 24'(i));
    repeat (400) @(negedge ref_clk);
    `CHK(start_ready, 1'b0, "buffer not full")
    for (int i = 0; i < 17; i++) begin
      s = 24'h1e0000 + 24'(i);
      `CHK(rdy_n, 1'b0, "word not waiting")
      host_u.sel(1'b1);
      host_u.ext_bits(24, w);
      `CHK(w, s, "buffered word")
      host_u.sel(1'b0);
      repeat (10) @(negedge ref_clk);
    end
    `CHK(rdy_n, 1'b1, "port not empty")
    `CHK(start_ready, 1'b1, "start not back")
    $display("test fill done");
  endtask

  initial begin
    sys_rst = 1'b1;
    port_role_strap = 1'b1;
    conv_start = 1'b0;
    conv_sample = '0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK(rdy_n, 1'b1, "reset ready")
    `CHK(sclk_oe, 1'b0, "reset clock drive")
    test_self();
    test_ext();
    test_drop();
    test_fill();
    end_of_test();
  end
endmodule
